// ===== bench/cpu_status_mode_bits_test.sv
// self-checking bench for the status register three mode bits
`timescale 1ns/1ps
`include "cpu_mode_defines.svh"
module cpu_status_mode_bits_test
	import cpu_mode_pkg::*;
();
	typedef struct packed {
		logic [2:0]  kind;
		logic [31:0] due;
		logic [39:0] val;
	} note_t;

	localparam int LIMIT = 4000;

	logic        clk, rstn, rom_strap_pin, soft_reset, instr_cycle;
	logic        legacy_compat_mode, sign_extend_mode, fractional_mode;
	logic        data_unit_saturate, wide_accumulate_mode, store_syntax_saturate;
	logic        addr_overflow, addr_overflow_neg;
	logic        rom_in_program_map, fetch_rom_map_select, branch_hazard;
	bit_op_t     bit_op;
	mmr_write_t  mmr_write;
	branch_cat_t branch_cat;
	mode_bits_t  mode;
	logic [15:0] addr_result, status_reg_three, addr_out, st;
	logic [16:0] mul_op_a, mul_op_b;
	logic [33:0] mul_product, mul_out;
	logic [39:0] store_value;
	logic [31:0] store_out, seed;
	logic [31:0] cyc = 32'h0000_0000;
	int          err_count, comparisons;
	note_t       notes[$];

	cpu_status_mode_bits dut (.clk, .rstn, .rom_strap_pin, .soft_reset, .bit_op, .mmr_write,
		.branch_cat, .instr_cycle, .legacy_compat_mode, .sign_extend_mode, .fractional_mode,
		.data_unit_saturate, .wide_accumulate_mode, .addr_result, .addr_overflow,
		.addr_overflow_neg, .mul_op_a, .mul_op_b, .mul_product, .store_value,
		.store_syntax_saturate, .status_reg_three, .mode, .rom_in_program_map,
		.fetch_rom_map_select, .branch_hazard, .addr_out, .mul_out, .store_out);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task results;
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : results

	task tally(input logic bad, input logic [39:0] e, input logic [39:0] g);
		comparisons++;
		if (bad) begin
			err_count++;
			$display("Error at %0t: expected %h got %h", $time, e, g);
		end
	endtask : tally

	task cmp_word(input logic [15:0] e, input logic [15:0] g);
		tally(g !== e, {24'h0, e}, {24'h0, g});
	endtask : cmp_word

	task cmp_wide(input logic [39:0] e, input logic [39:0] g);
		tally(g !== e, e, g);
	endtask : cmp_wide

	task cmp_flag(input logic e, input logic g);
		tally(g !== e, {39'h0, e}, {39'h0, g});
	endtask : cmp_flag

	// d is the latency: 0 for combinational views, 1 for registered results
	task note(input logic [2:0] k, input int d, input logic [39:0] v);
		notes.push_back({k, cyc + d, v});
	endtask : note

	task tick;
		@(posedge clk);
		#1;
	endtask : tick

	always @(posedge clk) begin
		cyc <= cyc + 32'd1;
		if (cyc == LIMIT) begin
			err_count++;
			results();
		end
	end

	// checks at the falling edge, before the driver moves the inputs again
	always @(negedge clk) begin : mon
		note_t n;
		while (notes.size() > 0 && notes[0].due == cyc) begin
			n = notes.pop_front();
			case (n.kind)
				3'h0: cmp_word(n.val[15:0], status_reg_three);
				3'h1: cmp_word(n.val[15:0], addr_out);
				3'h2: cmp_wide(n.val, {6'h0, mul_out});
				3'h3: cmp_wide(n.val, {8'h0, store_out});
				3'h4: cmp_flag(n.val[0], branch_hazard);
				3'h5: cmp_flag(n.val[0], fetch_rom_map_select);
				default: cmp_flag(n.val[0], rom_in_program_map);
			endcase
		end
	end

	task rst(input logic s);
		tick;
		rom_strap_pin = s;
		rstn = 1'b0;
		repeat (3) tick;
		cmp_word(16'h0000, status_reg_three);
		cmp_flag(1'b1, rom_in_program_map);
		rstn = 1'b1;
		st = {9'h0, s, 6'h0};
		repeat (5) tick;
		note(0, 0, {24'h0, st});
		note(6, 0, {39'h0, !s});
		tick;
	endtask : rst

	task do_bit(input logic [3:0] idx, input logic s);
		bit_op = {1'b1, s, idx};
		if (idx == 4'h6 || idx == 4'h5 || idx == 4'h1 || idx == 4'h0) st[idx] = s;
		note(0, 1, {24'h0, st});
		tick;
		bit_op = '0;
		tick;
	endtask : do_bit

	task do_mmr(input logic [15:0] d);
		mmr_write = {1'b1, d};
		st = d & 16'h0063;
		note(0, 1, {24'h0, st});
		tick;
		mmr_write = '0;
	endtask : do_mmr

	task walk(input int n1, input int n2, input logic r);
		for (int i = 0; i <= n1; i++) begin
			branch_cat = BRANCH_CAT1;
			note(4, 0, {39'h0, i < n1});
			if (i < n1) note(5, 0, {39'h0, !r});
			tick;
			branch_cat = BRANCH_CAT2;
			note(4, 0, {39'h0, i < n2});
			tick;
			branch_cat = BRANCH_CAT3;
			note(4, 0, 40'h0);
			instr_cycle = 1'b1;
			tick;
			instr_cycle = 1'b0;
		end
		branch_cat = BRANCH_NONE;
		repeat (2) tick;
		note(5, 0, {39'h0, r});
		note(6, 0, {39'h0, !r});
		tick;
	endtask : walk

	task dp;
		logic [31:0] r;
		logic [31:0] e;
		logic        sat;
		r = rnd();
		{addr_overflow_neg, addr_overflow, addr_result} = r[17:0];
		if (st[5] && r[16]) note(1, 1, r[17] ? 40'h8000 : 40'h7FFF);
		else note(1, 1, {24'h0, r[15:0]});
		r = rnd();
		mul_op_a = r[0] ? `MUL_CORNER_OPERAND : {r[31:16], r[1]};
		mul_op_b = r[0] ? `MUL_CORNER_OPERAND : r[17:1];
		mul_product = {r[3:2], rnd()};
		sat = mul_op_a == `MUL_CORNER_OPERAND && mul_op_b == `MUL_CORNER_OPERAND;
		if (sat && st[1] && fractional_mode && data_unit_saturate) note(2, 1, `MUL_POS_CLAMP);
		else note(2, 1, {6'h0, mul_product});
		r = rnd();
		store_value = {(r[1] ? (r[0] ? 8'hFF : 8'h80) : {7'h0, r[0]}), rnd()};
		store_syntax_saturate = !legacy_compat_mode && r[2];
		sat = legacy_compat_mode ? st[0] : store_syntax_saturate;
		e = store_value[31:0];
		if (sat && sign_extend_mode && $signed(store_value) < $signed(`STORE_NEG_LIMIT))
			e = `STORE_NEG_CLAMP;
		else if (sat && sign_extend_mode && $signed(store_value) > $signed(`STORE_POS_LIMIT))
			e = `STORE_POS_CLAMP;
		else if (sat && !sign_extend_mode && store_value > `STORE_POS_LIMIT)
			e = `STORE_POS_CLAMP;
		note(3, 1, {8'h0, e});
	endtask : dp

	initial begin
		logic [31:0] r;
		seed = 32'h3820;
		{rstn, rom_strap_pin, soft_reset, instr_cycle, store_syntax_saturate} = '0;
		{legacy_compat_mode, sign_extend_mode, fractional_mode} = '0;
		{data_unit_saturate, wide_accumulate_mode, addr_overflow, addr_overflow_neg} = '0;
		{bit_op, mmr_write, addr_result, mul_op_a, mul_op_b, mul_product, store_value} = '0;
		branch_cat = BRANCH_NONE;
		rst(1'b0);
		do_bit(4'h6, 1'b1);
		walk(4, 0, 1'b1);
		do_mmr(16'h0000);
		walk(5, 1, 1'b0);
		for (int k = 0; k < 5; k++) begin
			r = (k == 4) ? 32'h2 : ((k == 0) ? 32'h6 : ((k == 1) ? 32'h5 : {31'h0, k == 2}));
			do_bit(r[3:0], 1'b1);
			do_bit(r[3:0], 1'b0);
		end
		do_mmr(16'hFFFF);
		soft_reset = 1'b1;
		bit_op = {1'b1, 1'b1, 4'h5};
		st = st & 16'h0040;
		note(0, 1, {24'h0, st});
		tick;
		bit_op = '0;
		note(0, 1, {24'h0, st});
		tick;
		soft_reset = 1'b0;
		for (int i = 0; i < 64; i++) begin
			r = rnd();
			if (r[7:6] == 2'b00) do_mmr(r[31:16]);
			{legacy_compat_mode, sign_extend_mode, wide_accumulate_mode} = r[2:0];
			fractional_mode = r[3] | r[4];
			data_unit_saturate = r[3] | r[5];
			dp();
			tick;
		end
		do_mmr(16'h0022);
		rst(1'b1);
		repeat (2) tick;
		results();
	end
endmodule : cpu_status_mode_bits_test

// ===== rtl/cpu_mode_saturate.sv
// saturation datapaths steered by the mode bits
`timescale 1ns/1ps
`include "cpu_mode_defines.svh"
module cpu_mode_saturate
	import cpu_mode_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rstn,
	input  wire mode_bits_t        mode,
	input  wire logic              legacy_compat_mode,
	input  wire logic              sign_extend_mode,
	input  wire logic              fractional_mode,
	input  wire logic              data_unit_saturate,
	input  wire logic              wide_accumulate_mode,
	input  wire logic [15:0]       addr_result,
	input  wire logic              addr_overflow,
	input  wire logic              addr_overflow_neg,
	input  wire logic [16:0]       mul_op_a,
	input  wire logic [16:0]       mul_op_b,
	input  wire logic [33:0]       mul_product,
	input  wire logic [39:0]       store_value,
	input  wire logic              store_syntax_saturate,
	output logic      [15:0]       addr_out,
	output logic      [33:0]       mul_out,
	output logic      [31:0]       store_out
);
	logic [15:0] next_addr_out;
	logic [33:0] next_mul_out;
	logic [31:0] next_store_out;
	logic        store_sat_en;
	logic        mul_corner;
	logic [31:0] store_low;

	assign store_low = store_value[31:0];

	function automatic logic [31:0] store_clamp(input logic [39:0] v, input logic sgn);
		logic [31:0] r;
		r = v[31:0];
		if (sgn) begin
			if ($signed(v) > $signed(`STORE_POS_LIMIT)) r = `STORE_POS_CLAMP;
			else if ($signed(v) < $signed(`STORE_NEG_LIMIT)) r = `STORE_NEG_CLAMP;
		end else if (v > `STORE_POS_LIMIT) begin
			r = `STORE_POS_CLAMP;
		end
		return r;
	endfunction : store_clamp

	always_comb begin
		next_addr_out = addr_result;
		if (mode.addr_alu_saturate && addr_overflow) begin
			next_addr_out = addr_overflow_neg ? `ADDR_NEG_CLAMP : `ADDR_POS_CLAMP;
		end
		// product clamp sits ahead of any accumulate, independent of wide mode
		mul_corner = mode.mul_saturate && fractional_mode && data_unit_saturate
			&& mul_op_a == `MUL_CORNER_OPERAND && mul_op_b == `MUL_CORNER_OPERAND;
		next_mul_out = mul_corner ? {2'b00, `MUL_POS_CLAMP} : mul_product;
		// shift already applied upstream, so saturation sees the shifted value
		store_sat_en = legacy_compat_mode ? mode.store_saturate : store_syntax_saturate;
		next_store_out = store_sat_en ? store_clamp(store_value, sign_extend_mode)
			: store_value[31:0];
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			addr_out  <= 16'h0000;
			mul_out   <= 34'h0_0000_0000;
			store_out <= 32'h0000_0000;
		end else begin
			addr_out  <= next_addr_out;
			mul_out   <= next_mul_out;
			store_out <= next_store_out;
		end
	end

	a_addr_clamp_pos : assert property (@(posedge clk) disable iff (!rstn)
		mode.addr_alu_saturate && addr_overflow && !addr_overflow_neg
		|=> addr_out == `ADDR_POS_CLAMP) else $error("addr pos clamp wrong");
	a_addr_clamp_neg : assert property (@(posedge clk) disable iff (!rstn)
		mode.addr_alu_saturate && addr_overflow && addr_overflow_neg
		|=> addr_out == `ADDR_NEG_CLAMP) else $error("addr neg clamp wrong");
	a_addr_pass_off : assert property (@(posedge clk) disable iff (!rstn)
		!mode.addr_alu_saturate |=> addr_out == $past(addr_result))
		else $error("addr passed modified");
	a_mul_corner_sat : assert property (@(posedge clk) disable iff (!rstn)
		mode.mul_saturate && fractional_mode && data_unit_saturate
		&& mul_op_a == `MUL_CORNER_OPERAND && mul_op_b == `MUL_CORNER_OPERAND
		|=> mul_out == {2'b00, `MUL_POS_CLAMP}) else $error("mul corner not clamped");
	a_store_unsigned : assert property (@(posedge clk) disable iff (!rstn)
		legacy_compat_mode && mode.store_saturate && !sign_extend_mode
		&& store_value > `STORE_POS_LIMIT
		|=> store_out == `STORE_POS_CLAMP) else $error("unsigned store clamp");
	a_store_signed_neg : assert property (@(posedge clk) disable iff (!rstn)
		legacy_compat_mode && mode.store_saturate && sign_extend_mode
		&& $signed(store_value) < $signed(`STORE_NEG_LIMIT)
		|=> store_out == `STORE_NEG_CLAMP) else $error("signed store neg clamp");
	a_store_signed_pos : assert property (@(posedge clk) disable iff (!rstn)
		legacy_compat_mode && mode.store_saturate && sign_extend_mode
		&& $signed(store_value) > $signed(`STORE_POS_LIMIT)
		|=> store_out == `STORE_POS_CLAMP) else $error("signed store pos clamp");
	a_store_ignore : assert property (@(posedge clk) disable iff (!rstn)
		!legacy_compat_mode && !store_syntax_saturate
		|=> store_out == $past(store_low)) else $error("store bit not ignored");
endmodule : cpu_mode_saturate

// ===== rtl/cpu_status_mode_bits.sv
// status register three mode bits with rom map hazard tracking
`timescale 1ns/1ps
`include "cpu_mode_defines.svh"
module cpu_status_mode_bits
	import cpu_mode_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rstn,
	input  wire logic              rom_strap_pin,
	input  wire logic              soft_reset,
	input  wire bit_op_t           bit_op,
	input  wire mmr_write_t        mmr_write,
	input  wire branch_cat_t       branch_cat,
	input  wire logic              instr_cycle,
	input  wire logic              legacy_compat_mode,
	input  wire logic              sign_extend_mode,
	input  wire logic              fractional_mode,
	input  wire logic              data_unit_saturate,
	input  wire logic              wide_accumulate_mode,
	input  wire logic [15:0]       addr_result,
	input  wire logic              addr_overflow,
	input  wire logic              addr_overflow_neg,
	input  wire logic [16:0]       mul_op_a,
	input  wire logic [16:0]       mul_op_b,
	input  wire logic [33:0]       mul_product,
	input  wire logic [39:0]       store_value,
	input  wire logic              store_syntax_saturate,
	output logic      [15:0]       status_reg_three,
	output mode_bits_t             mode,
	output logic                   rom_in_program_map,
	output logic                   fetch_rom_map_select,
	output logic                   branch_hazard,
	output logic      [15:0]       addr_out,
	output logic      [33:0]       mul_out,
	output logic      [31:0]       store_out
);
	logic       strap_meta;
	logic       strap_sync;
	logic [1:0] strap_fill;
	logic       strap_taken;
	logic       next_strap_taken;
	mode_bits_t next_mode;
	logic       fetch_sel;
	logic       next_fetch_sel;
	logic [3:0] cat1_wait;
	logic [3:0] cat2_wait;
	logic [3:0] next_cat1_wait;
	logic [3:0] next_cat2_wait;
	logic       rom_changed;

	function automatic logic apply_bit(input logic cur, input bit_op_t op, input logic [3:0] pos);
		return (op.valid && op.bit_index == pos) ? op.set : cur;
	endfunction : apply_bit

	function automatic logic [3:0] dec_sat(input logic [3:0] v, input logic step);
		return (step && v != 4'h0) ? v - 4'h1 : v;
	endfunction : dec_sat

	// strap passes two flops; taken on third clock, once both hold the pin
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			strap_meta <= 1'b0;
			strap_sync <= 1'b0;
			strap_fill <= 2'b00;
		end else begin
			strap_meta <= rom_strap_pin;
			strap_sync <= strap_meta;
			strap_fill <= {strap_fill[0], 1'b1};
		end
	end

	always_comb begin
		next_mode        = mode;
		next_strap_taken = strap_fill[1];
		if (!strap_taken) begin
			next_mode.rom_map_select = strap_sync;
		end
		if (mmr_write.valid) begin
			next_mode.rom_map_select    = mmr_write.data[`ROM_MAP_SELECT_BIT];
			next_mode.addr_alu_saturate = mmr_write.data[`ADDR_ALU_SATURATE_BIT];
			next_mode.mul_saturate      = mmr_write.data[`MUL_SATURATE_BIT];
			next_mode.store_saturate    = mmr_write.data[`STORE_SATURATE_BIT];
		end
		next_mode.rom_map_select = apply_bit(next_mode.rom_map_select, bit_op,
			`ROM_MAP_SELECT_BIT);
		next_mode.addr_alu_saturate = apply_bit(next_mode.addr_alu_saturate, bit_op,
			`ADDR_ALU_SATURATE_BIT);
		next_mode.mul_saturate = apply_bit(next_mode.mul_saturate, bit_op,
			`MUL_SATURATE_BIT);
		next_mode.store_saturate = apply_bit(next_mode.store_saturate, bit_op,
			`STORE_SATURATE_BIT);
		// soft reset returns saturation bits only; rom select kept
		if (soft_reset) begin
			next_mode.addr_alu_saturate = 1'b0;
			next_mode.mul_saturate      = 1'b0;
			next_mode.store_saturate    = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mode        <= '0;
			strap_taken <= 1'b0;
		end else begin
			mode        <= next_mode;
			strap_taken <= next_strap_taken;
		end
	end

	// the fetch unit lags the register; models the documented hazard window
	assign rom_changed = next_mode.rom_map_select != mode.rom_map_select && strap_taken;

	always_comb begin
		next_cat1_wait = dec_sat(cat1_wait, instr_cycle);
		next_cat2_wait = dec_sat(cat2_wait, instr_cycle);
		next_fetch_sel = (next_cat1_wait == 4'h0) ? mode.rom_map_select : fetch_sel;
		if (!strap_taken) begin
			next_fetch_sel = strap_sync;
		end
		if (rom_changed) begin
			if (mmr_write.valid && !(bit_op.valid && bit_op.bit_index == `ROM_MAP_SELECT_BIT)) begin
				next_cat1_wait = `MMR_HAZARD_CAT1;
				next_cat2_wait = `MMR_HAZARD_CAT2;
			end else begin
				next_cat1_wait = `BIT_OP_HAZARD_CAT1;
				next_cat2_wait = `BIT_OP_HAZARD_CAT2;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fetch_sel <= 1'b0;
			cat1_wait <= 4'h0;
			cat2_wait <= 4'h0;
		end else begin
			fetch_sel <= next_fetch_sel;
			cat1_wait <= next_cat1_wait;
			cat2_wait <= next_cat2_wait;
		end
	end

	// category three never waits; the far side is trusted to space others
	always_comb begin
		case (branch_cat)
			BRANCH_CAT1: branch_hazard = cat1_wait != 4'h0;
			BRANCH_CAT2: branch_hazard = cat2_wait != 4'h0;
			BRANCH_CAT3: branch_hazard = 1'b0;
			default:     branch_hazard = 1'b0;
		endcase
	end

	assign fetch_rom_map_select = fetch_sel;
	assign rom_in_program_map   = !fetch_sel;

	always_comb begin
		status_reg_three = 16'h0000;
		status_reg_three[`ROM_MAP_SELECT_BIT]    = mode.rom_map_select;
		status_reg_three[`ADDR_ALU_SATURATE_BIT] = mode.addr_alu_saturate;
		status_reg_three[`MUL_SATURATE_BIT]      = mode.mul_saturate;
		status_reg_three[`STORE_SATURATE_BIT]    = mode.store_saturate;
	end

	cpu_mode_saturate u_sat (
		.clk                   (clk),
		.rstn                  (rstn),
		.mode                  (mode),
		.legacy_compat_mode    (legacy_compat_mode),
		.sign_extend_mode      (sign_extend_mode),
		.fractional_mode       (fractional_mode),
		.data_unit_saturate    (data_unit_saturate),
		.wide_accumulate_mode  (wide_accumulate_mode),
		.addr_result           (addr_result),
		.addr_overflow         (addr_overflow),
		.addr_overflow_neg     (addr_overflow_neg),
		.mul_op_a              (mul_op_a),
		.mul_op_b              (mul_op_b),
		.mul_product           (mul_product),
		.store_value           (store_value),
		.store_syntax_saturate (store_syntax_saturate),
		.addr_out              (addr_out),
		.mul_out               (mul_out),
		.store_out             (store_out)
	);

	a_soft_reset_keep : assert property (@(posedge clk) disable iff (!rstn)
		strap_taken && soft_reset && !mmr_write.valid && !bit_op.valid
		|=> $stable(mode.rom_map_select))
		else $error("soft reset moved rom select");
	a_soft_reset_sat : assert property (@(posedge clk) disable iff (!rstn)
		soft_reset
		|=> !mode.addr_alu_saturate && !mode.mul_saturate && !mode.store_saturate)
		else $error("soft reset kept a saturation bit");
	a_bit_set_rom : assert property (@(posedge clk) disable iff (!rstn)
		strap_taken && bit_op.valid && bit_op.bit_index == `ROM_MAP_SELECT_BIT
		|=> mode.rom_map_select == $past(bit_op.set))
		else $error("rom bit op lost");
	a_bit_set_addr : assert property (@(posedge clk) disable iff (!rstn)
		bit_op.valid && !soft_reset && bit_op.bit_index == `ADDR_ALU_SATURATE_BIT
		|=> mode.addr_alu_saturate == $past(bit_op.set))
		else $error("address saturate bit op lost");
	a_bit_set_mul : assert property (@(posedge clk) disable iff (!rstn)
		bit_op.valid && !soft_reset && bit_op.bit_index == `MUL_SATURATE_BIT
		|=> mode.mul_saturate == $past(bit_op.set))
		else $error("multiply saturate bit op lost");
	a_bit_set_store : assert property (@(posedge clk) disable iff (!rstn)
		bit_op.valid && !soft_reset && bit_op.bit_index == `STORE_SATURATE_BIT
		|=> mode.store_saturate == $past(bit_op.set))
		else $error("store saturate bit op lost");
	a_bit_ignored : assert property (@(posedge clk) disable iff (!rstn)
		strap_taken && bit_op.valid && !mmr_write.valid && !soft_reset
		&& !(bit_op.bit_index inside {`ROM_MAP_SELECT_BIT, `ADDR_ALU_SATURATE_BIT,
		`MUL_SATURATE_BIT, `STORE_SATURATE_BIT}) |=> $stable(status_reg_three))
		else $error("unused bit index changed the register");
	a_mmr_write_store : assert property (@(posedge clk) disable iff (!rstn)
		mmr_write.valid && !bit_op.valid && !soft_reset
		|=> status_reg_three == ($past(mmr_write.data) & `MODE_BITS_MASK)
		|| !strap_taken)
		else $error("mmr write not stored");
	a_status_layout : assert property (@(posedge clk) disable iff (!rstn)
		status_reg_three == {9'h000, mode.rom_map_select, mode.addr_alu_saturate, 3'h0,
		mode.mul_saturate, mode.store_saturate})
		else $error("register layout wrong");
	a_strap_load : assert property (@(posedge clk) disable iff (!rstn)
		$rose(strap_taken) |-> fetch_rom_map_select == $past(strap_sync))
		else $error("strap level not loaded");
	a_hazard_bitop : assert property (@(posedge clk) disable iff (!rstn)
		rom_changed && bit_op.valid && bit_op.bit_index == `ROM_MAP_SELECT_BIT
		|=> cat1_wait == `BIT_OP_HAZARD_CAT1 && cat2_wait == 4'h0)
		else $error("bit op hazard count");
	a_hazard_mmr : assert property (@(posedge clk) disable iff (!rstn)
		rom_changed && mmr_write.valid && !bit_op.valid
		|=> cat1_wait == `MMR_HAZARD_CAT1 && cat2_wait == `MMR_HAZARD_CAT2)
		else $error("mmr hazard count");
	a_wait_count_down : assert property (@(posedge clk) disable iff (!rstn)
		cat1_wait != 4'h0 && instr_cycle && !rom_changed
		|=> cat1_wait == $past(cat1_wait) - 4'h1)
		else $error("hazard wait did not count down");
	a_fetch_hold : assert property (@(posedge clk) disable iff (!rstn)
		strap_taken && cat1_wait > 4'h1
		|=> $stable(fetch_rom_map_select))
		else $error("fetch select moved inside the wait");
	a_fetch_follow : assert property (@(posedge clk) disable iff (!rstn)
		strap_taken && cat1_wait == 4'h1 && instr_cycle && !rom_changed
		|=> fetch_rom_map_select == $past(mode.rom_map_select))
		else $error("fetch select did not follow");
	a_rom_map_out : assert property (@(posedge clk) disable iff (!rstn)
		(rom_in_program_map == !fetch_rom_map_select) and (cat1_wait == 4'h0 && strap_taken
		&& $past(cat1_wait) == 4'h0 && $stable(mode.rom_map_select)
		|-> fetch_rom_map_select == mode.rom_map_select))
		else $error("rom map mismatch");
	a_rom_mapped : assert property (@(posedge clk) disable iff (!rstn)
		!fetch_rom_map_select |-> rom_in_program_map)
		else $error("rom missing from map");
	a_rom_unmapped : assert property (@(posedge clk) disable iff (!rstn)
		fetch_rom_map_select |-> !rom_in_program_map)
		else $error("rom left in map");
	a_cat1_stall : assert property (@(posedge clk) disable iff (!rstn)
		branch_cat == BRANCH_CAT1 && cat1_wait != 4'h0 |-> branch_hazard)
		else $error("cat1 not stalled");
	a_cat2_stall : assert property (@(posedge clk) disable iff (!rstn)
		branch_cat == BRANCH_CAT2 && cat2_wait != 4'h0 |-> branch_hazard)
		else $error("cat2 not stalled");
	a_hazard_clear : assert property (@(posedge clk) disable iff (!rstn)
		cat1_wait == 4'h0 && cat2_wait == 4'h0 |-> !branch_hazard)
		else $error("stall with no wait pending");
	a_cat3_free : assert property (@(posedge clk) disable iff (!rstn)
		branch_cat == BRANCH_CAT3 |-> !branch_hazard)
		else $error("cat3 stalled");
	a_reset_zero : assert property (@(posedge clk)
		!rstn |=> !mode.addr_alu_saturate && !mode.mul_saturate)
		else $error("reset value");
endmodule : cpu_status_mode_bits

// ===== shared/cpu_mode_defines.svh
// constants for the status register three mode bits
`ifndef CPU_MODE_DEFINES_SVH
`define CPU_MODE_DEFINES_SVH
`define ROM_MAP_SELECT_BIT      4'h6
`define ADDR_ALU_SATURATE_BIT   4'h5
`define MUL_SATURATE_BIT        4'h1
`define STORE_SATURATE_BIT      4'h0
`define STATUS_REG_THREE_RESET  16'h0000
`define MODE_BITS_MASK          16'h0063
`define ADDR_POS_CLAMP          16'h7FFF
`define ADDR_NEG_CLAMP          16'h8000
`define MUL_CORNER_OPERAND      17'h1_8000
`define MUL_POS_CLAMP           32'h7FFF_FFFF
`define STORE_POS_CLAMP         32'h7FFF_FFFF
`define STORE_NEG_CLAMP         32'h8000_0000
`define STORE_POS_LIMIT         40'h00_7FFF_FFFF
`define STORE_NEG_LIMIT         40'hFF_8000_0000
`define BIT_OP_HAZARD_CAT1      4'h4
`define BIT_OP_HAZARD_CAT2      4'h0
`define BIT_OP_HAZARD_CAT3      4'h0
`define MMR_HAZARD_CAT1         4'h5
`define MMR_HAZARD_CAT2         4'h1
`define MMR_HAZARD_CAT3         4'h0
`endif

// ===== shared/cpu_mode_pkg.sv
// types shared by the status register three mode logic
package cpu_mode_pkg;
	typedef struct packed {
		logic       rom_map_select;
		logic       addr_alu_saturate;
		logic       mul_saturate;
		logic       store_saturate;
	} mode_bits_t;

	typedef struct packed {
		logic       valid;
		logic       set;
		logic [3:0] bit_index;
	} bit_op_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] data;
	} mmr_write_t;

	typedef enum logic [1:0] {
		BRANCH_NONE,
		BRANCH_CAT1,
		BRANCH_CAT2,
		BRANCH_CAT3
	} branch_cat_t;
endpackage : cpu_mode_pkg
